/* verilog/tx_timing_cfg.svh */
`ifndef TX_TIMING_CFG_SVH
`define TX_TIMING_CFG_SVH

// register indices, byte address is index times four
`define TT_OPTS_IDX 6'h06
`define TT_LINK_IDX 6'h07
`define TT_STAT_IDX 6'h08

// transmit_timing_options fields
`define TT_STORE_BYP_BIT 0
`define TT_PLL_LO_BIT 2
`define TT_PLL_HI_BIT 3
`define TT_OCLK_LO_BIT 4
`define TT_OCLK_HI_BIT 5
`define TT_OPTS_MASK 8'h3D
`define TT_OPTS_RST 8'h00

// link_control fields
`define TT_LOOP_BIT 0
`define TT_CLKDIR_BIT 1
`define TT_UNI_BIT 2
`define TT_LINK_MASK 8'h07
`define TT_LINK_RST 8'h00

`endif

/* verilog/tx_timing_pkg.sv */
package tx_timing_pkg;

    typedef enum logic [1:0] {
        SRC_JAT = 2'b00,
        SRC_REF = 2'b01,
        SRC_FIFO_IN = 2'b10
    } out_src_e;

    typedef enum logic [1:0] {
        REF_FIFO_IN = 2'b00,
        REF_BACKPLANE = 2'b01,
        REF_RECOVERED = 2'b10,
        REF_TX_REF = 2'b11
    } pll_ref_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } avmm_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_s;

    // external clock pins, all sampled on i_clock
    typedef struct packed {
        logic backplane_tx_clk;
        logic tx_ref_clk_in;
        logic rx_recovered_clk;
        logic jat_clk;
        logic store_clk;
    } clk_pins_s;

    typedef struct packed {
        logic backplane_data;
        logic store_data;
        logic rx_data;
        logic frame_pulse;
    } data_pins_s;

endpackage

/* verilog/transmit_timing_source_select.sv */
// Local design decision: the Avalon-MM interface to the registers.
`include "tx_timing_cfg.svh"

module transmit_timing_source_select (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // register bus
    input tx_timing_pkg::avmm_req_s i_avmm,
    output tx_timing_pkg::avmm_rsp_s o_avmm,
    // pins from outside
    input tx_timing_pkg::clk_pins_s i_clk_pins,
    input tx_timing_pkg::data_pins_s i_data_pins,
    // elastic store and attenuator side
    output logic o_store_out_clk,
    output logic o_store_out_data,
    output logic o_fifo_in_clk,
    output logic o_fifo_in_data,
    output logic o_fifo_out_clk,
    output logic o_pll_ref,
    output logic o_jat_enable,
    // line side
    output logic o_tx_line_clk_out,
    output logic o_unipolar_data,
    output logic o_unipolar_frame,
    output logic o_bipolar_pos,
    output logic o_bipolar_neg,
    // backplane clock, driven when configured as output
    output logic o_backplane_tx_clk,
    output logic o_backplane_tx_clk_oe
);
    import tx_timing_pkg::*;

    localparam int NSYNC = 9;

    logic [NSYNC-1:0] pin_meta;
    logic [NSYNC-1:0] pin_sync;
    logic [7:0] opts;
    logic [7:0] link;
    logic ack;
    logic first_cycle;
    logic line_prev;
    logic mark_phase;
    logic [31:0] readdata;
    logic bp_clk, ref_clk, rec_clk, jat_clk, st_clk;
    logic bp_data, st_data, rx_data, frame;
    logic store_bypass, loop_en, clk_dir, uni_sel;
    logic sel_hi, sel_lo;
    logic [1:0] ref_code;
    out_src_e out_src;
    pll_ref_e pll_ref;
    logic next_store_clk, next_store_data;
    logic next_fifo_in_clk, next_fifo_in_data;
    logic next_fifo_out_clk, next_pll_ref;
    logic req, bad_ref_sel, bad_fifo_sel, bad_dir_sel;
    logic [5:0] idx;
    logic [7:0] status;

    // pin inputs are asynchronous to i_clock
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {i_clk_pins, i_data_pins};
            pin_sync <= pin_meta;
        end
    end

    assign {bp_clk, ref_clk, rec_clk, jat_clk, st_clk} = pin_sync[8:4];
    assign {bp_data, st_data, rx_data, frame} = pin_sync[3:0];

    // field decode
    assign store_bypass = opts[`TT_STORE_BYP_BIT];
    assign sel_hi = opts[`TT_OCLK_HI_BIT];
    assign sel_lo = opts[`TT_OCLK_LO_BIT];
    assign ref_code = {opts[`TT_PLL_HI_BIT], opts[`TT_PLL_LO_BIT]};
    assign loop_en = link[`TT_LOOP_BIT];
    assign clk_dir = link[`TT_CLKDIR_BIT];
    assign uni_sel = link[`TT_UNI_BIT];

    // bus slave: one wait cycle, answer on the second edge
    assign req = i_avmm.read | i_avmm.write;
    assign idx = i_avmm.address[7:2];
    // one driver for the whole response struct
    assign o_avmm = '{readdata: readdata, waitrequest: req & ~ack};

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            opts <= `TT_OPTS_RST;
            link <= `TT_LINK_RST;
        end else if (i_avmm.write && ack) begin
            if (idx == `TT_OPTS_IDX) begin
                opts <= i_avmm.writedata[7:0] & `TT_OPTS_MASK;
            end
            if (idx == `TT_LINK_IDX) begin
                link <= i_avmm.writedata[7:0] & `TT_LINK_MASK;
            end
        end
    end

    // misuse flags only report, hardware still follows the bits
    assign bad_ref_sel = (out_src == SRC_REF) && (pll_ref != REF_TX_REF);
    assign bad_fifo_sel = (out_src == SRC_FIFO_IN) && (pll_ref != REF_FIFO_IN);
    assign bad_dir_sel = !clk_dir && !ref_code[1];
    assign status = {bad_dir_sel, bad_fifo_sel, bad_ref_sel, o_jat_enable,
                     out_src, pll_ref};

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            readdata <= '0;
        end else if (i_avmm.read && !ack) begin
            unique case (idx)
                `TT_OPTS_IDX: readdata <= {24'h000000, opts};
                `TT_LINK_IDX: readdata <= {24'h000000, link};
                `TT_STAT_IDX: readdata <= {24'h000000, status};
                default: readdata <= 32'h00000000;
            endcase
        end
    end

    // elastic store path
    always_comb begin
        if (store_bypass) begin
            next_store_clk = bp_clk;
            next_store_data = bp_data;
        end else begin
            next_store_clk = st_clk;
            next_store_data = st_data;
        end
    end

    // attenuator input: loopback swaps in the receive side
    always_comb begin
        if (loop_en) begin
            next_fifo_in_clk = rec_clk;
            next_fifo_in_data = rx_data;
        end else begin
            next_fifo_in_clk = next_store_clk;
            next_fifo_in_data = next_store_data;
        end
    end

    // output clock source
    always_comb begin
        if (sel_hi) begin
            out_src = SRC_FIFO_IN;
        end else if (sel_lo) begin
            out_src = SRC_REF;
        end else begin
            out_src = SRC_JAT;
        end
    end

    always_comb begin
        unique case (out_src)
            SRC_JAT: next_fifo_out_clk = jat_clk;
            SRC_REF: next_fifo_out_clk = ref_clk;
            SRC_FIFO_IN: next_fifo_out_clk = next_fifo_in_clk;
            default: next_fifo_out_clk = jat_clk;
        endcase
    end

    // pll reference
    assign pll_ref = pll_ref_e'(ref_code);

    always_comb begin
        unique case (pll_ref)
            REF_FIFO_IN: next_pll_ref = next_fifo_in_clk;
            REF_BACKPLANE: next_pll_ref = bp_clk;
            REF_RECOVERED: next_pll_ref = rec_clk;
            REF_TX_REF: next_pll_ref = ref_clk;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_store_out_clk <= 1'b0;
            o_store_out_data <= 1'b0;
            o_fifo_in_clk <= 1'b0;
            o_fifo_in_data <= 1'b0;
            o_fifo_out_clk <= 1'b0;
            o_pll_ref <= 1'b0;
            o_jat_enable <= 1'b1;
        end else begin
            o_store_out_clk <= next_store_clk;
            o_store_out_data <= next_store_data;
            o_fifo_in_clk <= next_fifo_in_clk;
            o_fifo_in_data <= next_fifo_in_data;
            o_fifo_out_clk <= next_fifo_out_clk;
            o_pll_ref <= next_pll_ref;
            o_jat_enable <= (out_src == SRC_JAT);
        end
    end

    // backplane clock as output follows the line clock
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_backplane_tx_clk <= 1'b0;
            o_backplane_tx_clk_oe <= 1'b0;
        end else begin
            o_backplane_tx_clk <= next_fifo_out_clk;
            o_backplane_tx_clk_oe <= !clk_dir;
        end
    end

    // line coding, marks alternate polarity on each rising line clock
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            line_prev <= 1'b0;
            mark_phase <= 1'b0;
            o_bipolar_pos <= 1'b0;
            o_bipolar_neg <= 1'b0;
            o_unipolar_data <= 1'b0;
            o_unipolar_frame <= 1'b0;
        end else begin
            line_prev <= next_fifo_out_clk;
            if (uni_sel) begin
                o_bipolar_pos <= 1'b0;
                o_bipolar_neg <= 1'b0;
                o_unipolar_data <= next_fifo_in_data;
                o_unipolar_frame <= frame;
            end else begin
                o_unipolar_data <= 1'b0;
                o_unipolar_frame <= 1'b0;
                if (next_fifo_out_clk && !line_prev) begin
                    o_bipolar_pos <= next_fifo_in_data && !mark_phase;
                    o_bipolar_neg <= next_fifo_in_data && mark_phase;
                    mark_phase <= mark_phase ^ next_fifo_in_data;
                end
            end
        end
    end

    // unipolar line clock only in unipolar mode
    logic uni_clk;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            uni_clk <= 1'b0;
        end else begin
            uni_clk <= uni_sel & next_fifo_out_clk;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    property p_store_bypass;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(store_bypass) |-> o_store_out_data == $past(bp_data);
    endproperty
    a_store_bypass: assert property (p_store_bypass)
        else $error("bypass data mismatch");

    property p_store_inpath;
        @(posedge i_clock) disable iff (!i_nrst)
        !$past(store_bypass) |-> o_store_out_clk == $past(st_clk);
    endproperty
    a_store_inpath: assert property (p_store_inpath)
        else $error("store clock mismatch");

    property p_out_jat;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(!sel_hi && !sel_lo) |-> o_fifo_out_clk == $past(jat_clk) && o_jat_enable;
    endproperty
    a_out_jat: assert property (p_out_jat)
        else $error("attenuated clock not selected");

    property p_out_ref;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(!sel_hi && sel_lo) |-> o_fifo_out_clk == $past(ref_clk);
    endproperty
    a_out_ref: assert property (p_out_ref)
        else $error("reference clock not selected");

    property p_out_fifo_in;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(sel_hi) |-> o_fifo_out_clk == o_fifo_in_clk && !o_jat_enable;
    endproperty
    a_out_fifo_in: assert property (p_out_fifo_in)
        else $error("fifo input clock not passed");

    property p_pll_rec;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(ref_code) == 2'h2 |-> o_pll_ref == $past(rec_clk);
    endproperty
    a_pll_rec: assert property (p_pll_rec)
        else $error("pll reference wrong");

    property p_loop_data;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(loop_en && !sel_hi && !sel_lo && !ref_code[0])
            |-> o_fifo_in_data == $past(rx_data) && o_jat_enable;
    endproperty
    a_loop_data: assert property (p_loop_data)
        else $error("loopback data wrong");

    property p_equal_bp;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(sel_hi && store_bypass && !loop_en) |-> o_fifo_out_clk == $past(bp_clk);
    endproperty
    a_equal_bp: assert property (p_equal_bp)
        else $error("line clock differs from backplane");

    property p_equal_ref;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(!sel_hi && sel_lo && ref_code == 2'h3)
            |-> !o_jat_enable && o_fifo_out_clk == o_pll_ref;
    endproperty
    a_equal_ref: assert property (p_equal_ref)
        else $error("line clock differs from reference");

    property p_bipolar_quiet;
        @(posedge i_clock) disable iff (!i_nrst)
        $past(!uni_sel) |-> !o_unipolar_data && !o_unipolar_frame && !o_tx_line_clk_out;
    endproperty
    a_bipolar_quiet: assert property (p_bipolar_quiet)
        else $error("unipolar outputs active");

    property p_reset_clear;
        @(posedge i_clock) disable iff (!i_nrst)
        first_cycle |-> opts == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("options not cleared");

    property p_unused_zero;
        @(posedge i_clock) disable iff (!i_nrst)
        i_avmm.read && ack && idx == `TT_OPTS_IDX |-> readdata[7:6] == 2'h0 && !readdata[1];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read nonzero");

    c_loopback: cover property (@(posedge i_clock) disable iff (!i_nrst)
        loop_en && out_src == SRC_JAT);
    c_ref_mode: cover property (@(posedge i_clock) disable iff (!i_nrst)
        out_src == SRC_REF && pll_ref == REF_TX_REF);
    c_bp_out: cover property (@(posedge i_clock) disable iff (!i_nrst)
        o_backplane_tx_clk_oe && o_backplane_tx_clk);

    // line clock pin always carries the unipolar clock, held low in bipolar mode
    assign o_tx_line_clk_out = uni_clk;

endmodule

/* tb/line_side_model.sv */
module line_side_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // backplane clock pin as driven by the device
    input wire logic i_bp_clk,
    input wire logic i_bp_clk_oe,
    // levels seen at the device pins
    output tx_timing_pkg::clk_pins_s o_clk_pins,
    output tx_timing_pkg::data_pins_s o_data_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import tx_timing_pkg::*;

    // distinct half periods so every source can be told apart at the outputs
    localparam logic [3:0] HALF [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB, 4'hA, 4'hD};
    logic [3:0] cnt [9];
    logic [8:0] lvl;

    // steady, unrelated sources: no jitter, backplane plesiochronous
    always_ff @(posedge i_clock or negedge i_nrst) begin
        for (int k = 0; k < 9; k++) begin
            if (!i_nrst) begin
                cnt[k] <= 4'h0;
                lvl[k] <= 1'b0;
            end else if (cnt[k] == HALF[k] - 4'h1) begin
                cnt[k] <= 4'h0;
                lvl[k] <= ~lvl[k];
            end else begin
                cnt[k] <= cnt[k] + 4'h1;
            end
        end
    end

    // backplane wire level: device wins while it drives the pin
    assign o_clk_pins = {i_bp_clk_oe ? i_bp_clk : lvl[0], lvl[1], lvl[2], lvl[3], lvl[4]};
    assign o_data_pins = {lvl[5], lvl[6], lvl[7], lvl[8]};
endmodule

/* tb/tb_transmit_timing_source_select.sv */
module tb_transmit_timing_source_select;
    timeunit 1ns;
    timeprecision 1ps;
    import tx_timing_pkg::*;

    logic i_clock;
    logic i_nrst;
    avmm_req_s req;
    avmm_rsp_s rsp;
    clk_pins_s clk_pins;
    data_pins_s data_pins;
    logic [8:0] obs;
    logic [3:0] line;
    logic bp_oe;
    logic [12:0] all_out;
    assign all_out = {line, obs};
    int fails;
    int checked;

    transmit_timing_source_select dut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_avmm(req), .o_avmm(rsp),
        .i_clk_pins(clk_pins), .i_data_pins(data_pins),
        .o_store_out_clk(obs[3]), .o_store_out_data(obs[6]),
        .o_fifo_in_clk(obs[4]), .o_fifo_in_data(obs[5]),
        .o_fifo_out_clk(obs[0]), .o_pll_ref(obs[2]), .o_jat_enable(obs[7]),
        .o_tx_line_clk_out(obs[1]), .o_unipolar_data(line[0]), .o_unipolar_frame(line[1]),
        .o_bipolar_pos(line[2]), .o_bipolar_neg(line[3]),
        .o_backplane_tx_clk(obs[8]), .o_backplane_tx_clk_oe(bp_oe)
    );

    line_side_model partner (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_bp_clk(obs[8]), .i_bp_clk_oe(bp_oe),
        .o_clk_pins(clk_pins), .o_data_pins(data_pins)
    );

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    task automatic end_sim();
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // waitrequest is sampled as it stood just before each edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge i_clock);
        req <= '{read: ~wr, write: wr, address: a, writedata: {24'h000000, d}};
        n = 0;
        @(posedge i_clock);
        while (rsp.waitrequest !== 1'b0 && n < 50) begin
            @(posedge i_clock);
            n++;
        end
        if (n >= 50) begin
            fails++;
        end
        q = rsp.readdata[7:0];
        req <= '0;
    endtask

    // settle time covers the two-flop pin paths and the output register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
        repeat (10) @(posedge i_clock);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, q, exp);
    endtask

    // half period in cycles identifies which source reached the output
    task automatic hp(input string nm, input logic [3:0] s, input logic [7:0] exp);
        logic v;
        int n;
        @(posedge i_clock);
        v = all_out[s];
        n = 0;
        while (all_out[s] === v && n < 60) begin
            @(posedge i_clock);
            n++;
        end
        v = all_out[s];
        n = 0;
        while (all_out[s] === v && n < 60) begin
            @(posedge i_clock);
            n++;
        end
        chk(nm, n[7:0], exp);
    endtask

    task automatic quiet(input string nm, input logic [12:0] m);
        logic [7:0] c;
        c = 8'h00;
        repeat (60) begin
            @(posedge i_clock);
            if ((all_out & m) !== 13'h0000) begin
                c = c + 8'h01;
            end
        end
        chk(nm, c, 8'h00);
    endtask

    // both mark polarities must show up while data toggles
    task automatic marks();
        logic [7:0] c;
        c = 8'h00;
        repeat (100) begin
            @(posedge i_clock);
            c = c | {6'h00, line[3], line[2]};
        end
        chk("bipolar_marks", c, 8'h03);
    endtask

    task automatic t_reset();
        rdc("options", 8'h18, 8'h00);
        rdc("link", 8'h1C, 8'h00);
        chk("jat_enable", {7'h00, obs[7]}, 8'h01);
        hp("fifo_out_clk", 4'h0, 8'h06);
    endtask

    task automatic t_unused();
        wr(8'h18, 8'hFF);
        rdc("options", 8'h18, 8'h3D);
        wr(8'h3C, 8'h5A);
        rdc("unmapped", 8'h3C, 8'h00);
        rdc("options", 8'h18, 8'h3D);
        rdc("status", 8'h20, 8'h4B);
    endtask

    task automatic t_out_sel();
        wr(8'h1C, 8'h06); // unipolar so the line clock pin runs
        chk("bp_oe", {7'h00, bp_oe}, 8'h00);
        wr(8'h18, 8'h00);
        hp("fifo_out_clk", 4'h0, 8'h06);
        chk("jat_enable", {7'h00, obs[7]}, 8'h01);
        wr(8'h18, 8'h1C); // reference 11 with select 01
        hp("fifo_out_clk", 4'h0, 8'h04);
        hp("line_clk", 4'h1, 8'h04);
        chk("jat_enable", {7'h00, obs[7]}, 8'h00);
        wr(8'h18, 8'h21); // reference 00 with select 10
        hp("fifo_out_clk", 4'h0, 8'h03);
        hp("line_clk", 4'h1, 8'h03);
        wr(8'h18, 8'h31); // reference 00 with select 11
        hp("fifo_out_clk", 4'h0, 8'h03);
        chk("jat_enable", {7'h00, obs[7]}, 8'h00);
    endtask

    task automatic t_pll_ref();
        wr(8'h18, 8'h01);
        hp("pll_ref", 4'h2, 8'h03);
        wr(8'h18, 8'h09);
        hp("pll_ref", 4'h2, 8'h05);
        wr(8'h18, 8'h0D);
        hp("pll_ref", 4'h2, 8'h04);
        wr(8'h1C, 8'h03);
        wr(8'h18, 8'h05);
        hp("pll_ref", 4'h2, 8'h03);
        wr(8'h18, 8'h01);
        hp("pll_ref", 4'h2, 8'h05);
    endtask

    task automatic t_bypass();
        wr(8'h1C, 8'h02);
        hp("store_out_clk", 4'h3, 8'h03);
        hp("store_out_data", 4'h6, 8'h09);
        hp("fifo_in_data", 4'h5, 8'h09);
        wr(8'h18, 8'h00);
        hp("store_out_clk", 4'h3, 8'h07);
        hp("store_out_data", 4'h6, 8'h0B);
    endtask

    task automatic t_loopback();
        wr(8'h1C, 8'h03);
        hp("fifo_in_clk", 4'h4, 8'h05);
        hp("fifo_in_data", 4'h5, 8'h0A);
        chk("jat_enable", {7'h00, obs[7]}, 8'h01);
    endtask

    task automatic t_line_mode();
        wr(8'h1C, 8'h00); // backplane clock driven, bipolar line
        chk("bp_oe", {7'h00, bp_oe}, 8'h01);
        wr(8'h18, 8'h11);
        rdc("status", 8'h20, 8'hA4);
        wr(8'h18, 8'h09); // recovered reference only
        rdc("status", 8'h20, 8'h12);
        quiet("unipolar_out", 13'h0602);
        marks();
        wr(8'h1C, 8'h04);
        wr(8'h18, 8'h1D); // reference 11 with select 01
        rdc("status", 8'h20, 8'h07);
        quiet("bipolar_out", 13'h1800);
        hp("unipolar_data", 4'h9, 8'h09);
        hp("unipolar_frame", 4'hA, 8'h0D);
        hp("backplane_out", 4'h8, 8'h04);
    endtask

    initial begin
        fails = 0;
        checked = 0;
        req = '0;
        i_nrst = 1'b0;
        repeat (20) @(posedge i_clock);
        i_nrst <= 1'b1;
        t_reset();
        t_unused();
        t_out_sel();
        t_pll_ref();
        t_bypass();
        t_loopback();
        t_line_mode();
        end_sim();
    end

    // all scenarios need a few thousand cycles at most
    initial begin
        repeat (30000) @(posedge i_clock);
        fails++;
        end_sim();
    end
endmodule
